// >>> rtl/tca_regs.svh
// Purpose: Register offsets, field positions and reset values of the timer
// Assumes: Eight-bit register port, one register per byte address
// Notes:   Definitions only
`ifndef TCA_REGS_SVH
`define TCA_REGS_SVH

`define TCA_CMP_LO      8'h2d
`define TCA_CMP_HI      8'h2e
`define TCA_CAP_LO      8'h2f
`define TCA_CAP_HI      8'h30
`define TCA_CTL         8'h31
`define TCA_MODE        8'h32

// Control register bits
`define TCA_CTL_RUN     0
`define TCA_CTL_DBF     1
`define TCA_CTL_OVE     2
`define TCA_CTL_ACAP    3

// Mode register fields
`define TCA_MODE_M_LO   0
`define TCA_MODE_M_HI   2
`define TCA_MODE_CK_LO  3
`define TCA_MODE_CK_HI  4
`define TCA_MODE_TED    5
`define TCA_MODE_METT   6

// Operating mode codes
`define TCA_M_TIMER0    3'h0
`define TCA_M_TIMER1    3'h1
`define TCA_M_EVENT     3'h2
`define TCA_M_TRIG      3'h4
`define TCA_M_WINDOW    3'h5

`define TCA_CMP_RESET   16'hffff
`define TCA_CAP_RESET   16'hffff
`define TCA_TMP_RESET   8'hff
`define TCA_PRE_W       10

`endif

// >>> rtl/tca_pkg.sv
// Purpose: Types shared by the timer design
// Assumes: Constants come from tca_regs.svh
// Notes:   One packed struct carries all timer state
`include "tca_regs.svh"

package tca_pkg;

  typedef struct packed {
    logic [`TCA_PRE_W-1:0] pre;
    logic [15:0]           cnt;
    logic [15:0]           act;
    logic [15:0]           dbuf;
    logic [15:0]           cap;
    logic [7:0]            tmp;
    logic [7:0]            rdata;
    logic                  run;
    logic                  dbf;
    logic                  ove;
    logic                  acap;
    logic [2:0]            mode;
    logic [1:0]            ck;
    logic                  ted;
    logic                  mett;
    logic                  going;
    logic                  sync1;
    logic                  sync2;
    logic                  prev;
    logic                  irq;
  } tca_state_t;

endpackage

// >>> rtl/tca_timer.sv
// Purpose: Sixteen-bit up-counter timer with trigger, event and window modes
// Assumes: Source clocks are taps of a free prescaler on CLK
// Notes:   Pulse width and pulse generator modes are not built here
`timescale 1ns/1ps
`default_nettype none
`include "tca_regs.svh"

module tca_timer
  import tca_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       TIMER_INPUT_PIN,
  output logic            TIMER_INTERRUPT_REQUEST
);

  tca_state_t st;
  tca_state_t next_st;

  logic tick;
  logic rise;
  logic fall;
  logic sel_edge;
  logic opp_edge;
  logic cnt_ev;
  logic hit;

  // Source clock taps: 2^10, 2^6, 2^2 and 2 system clocks
  always_comb begin
    unique case (st.ck)
      2'h0:    tick = &st.pre;
      2'h1:    tick = &st.pre[5:0];
      2'h2:    tick = &st.pre[1:0];
      2'h3:    tick = st.pre[0];
    endcase
  end

  // The slowest source tap needs ten prescaler bits
  if (`TCA_PRE_W < 10) begin : g_pre_chk
    $error("prescaler too narrow for the slowest source tap");
  end

  // Edges come from the second and third stages only
  assign rise     = st.sync2 & ~st.prev;
  assign fall     = ~st.sync2 & st.prev;
  assign sel_edge = st.ted ? fall : rise;
  assign opp_edge = st.ted ? rise : fall;

  always_comb begin
    unique case (st.mode)
      `TCA_M_TIMER0, `TCA_M_TIMER1: cnt_ev = tick;
      `TCA_M_TRIG:   cnt_ev = st.going & tick;
      `TCA_M_EVENT:  cnt_ev = sel_edge;
      `TCA_M_WINDOW: cnt_ev = tick & (st.sync2 == ~st.ted);
      default:       cnt_ev = 1'b0;
    endcase
  end

  // Equality only, so a compare below the count waits for the wrap
  assign hit = st.run & cnt_ev & (st.cnt == st.act);

  always_comb begin
    next_st       = st;
    next_st.irq   = 1'b0;
    next_st.rdata = 8'h00;
    next_st.pre   = st.pre + `TCA_PRE_W'(1);
    next_st.sync1 = TIMER_INPUT_PIN;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    if (st.run) begin
      if (hit) begin
        next_st.cnt = 16'h0000;
        next_st.irq = 1'b1;
        if (st.dbf) begin
          next_st.act = st.dbuf;
        end
      end else if (cnt_ev) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      if (st.mode == `TCA_M_TRIG) begin
        if (!st.going) begin
          next_st.going = sel_edge;
        end else if (st.mett && opp_edge) begin
          next_st.going = 1'b0;
          next_st.cnt   = 16'h0000;
        end
        // With retrigger off, edges are not looked at once the count has started
      end
    end

    if (WR) begin
      if (ADDR == `TCA_CMP_LO) begin
        next_st.tmp = WDATA;
      end
      if (ADDR == `TCA_CMP_HI) begin
        next_st.dbuf = {WDATA, st.tmp};
        // Running with buffer on: compare keeps its old value
        if (!(st.dbf && st.run)) begin
          next_st.act = {WDATA, st.tmp};
        end
      end
      if (ADDR == `TCA_CTL) begin
        next_st.run = WDATA[`TCA_CTL_RUN];
        next_st.dbf = WDATA[`TCA_CTL_DBF];
        if (!st.run) begin
          next_st.ove = WDATA[`TCA_CTL_OVE];
        end
        // Auto capture cannot change in the write that stops the timer
        if (!(st.run && !WDATA[`TCA_CTL_RUN])) begin
          next_st.acap = WDATA[`TCA_CTL_ACAP];
        end
      end
      if (ADDR == `TCA_MODE && !st.run) begin
        next_st.mode = WDATA[`TCA_MODE_M_HI:`TCA_MODE_M_LO];
        next_st.ck   = WDATA[`TCA_MODE_CK_HI:`TCA_MODE_CK_LO];
        next_st.ted  = WDATA[`TCA_MODE_TED];
        next_st.mett = WDATA[`TCA_MODE_METT];
      end
    end

    if (!next_st.run) begin
      next_st.cnt   = 16'h0000;
      next_st.going = 1'b0;
    end

    if (RD) begin
      unique case (ADDR)
        `TCA_CMP_LO:
          next_st.rdata = st.dbf ? st.dbuf[7:0] : st.act[7:0];
        `TCA_CMP_HI:
          next_st.rdata = st.dbf ? st.dbuf[15:8] : st.act[15:8];
        `TCA_CAP_LO: begin
          if (st.acap) begin
            // Stopped timer reads zero and clears the held high byte
            next_st.cap   = st.run ? st.cnt : 16'h0000;
            next_st.rdata = st.run ? st.cnt[7:0] : 8'h00;
          end else begin
            next_st.rdata = st.cap[7:0];
          end
        end
        `TCA_CAP_HI:
          next_st.rdata = st.cap[15:8];
        `TCA_CTL:
          next_st.rdata = {4'h0, st.acap, st.ove, st.dbf, st.run};
        `TCA_MODE:
          next_st.rdata = {1'b0, st.mett, st.ted, st.ck, st.mode};
        default:
          next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st       <= '0;
      st.act   <= `TCA_CMP_RESET;
      st.dbuf  <= `TCA_CMP_RESET;
      st.cap   <= `TCA_CAP_RESET;
      st.tmp   <= `TCA_TMP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA                   = st.rdata;
  assign TIMER_INTERRUPT_REQUEST = st.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_hi_write;
    WR && ADDR == `TCA_CMP_HI;
  endsequence

  sequence s_trig_going;
    st.run && st.mode == `TCA_M_TRIG && st.going && st.mett;
  endsequence

  a_low_held: assert property (
    WR && ADDR == `TCA_CMP_LO && !hit
    |=> $stable(st.act) && $stable(st.dbuf) && st.tmp == $past(WDATA))
    else $error("low byte write changed the compare value");

  a_high_load: assert property (
    s_hi_write ##0 !(st.dbf && st.run)
    |=> st.act == {$past(WDATA), $past(st.tmp)})
    else $error("high byte write did not load sixteen bits");

  a_dbuf_hold: assert property (
    s_hi_write ##0 (st.dbf && st.run && !hit)
    |=> $stable(st.act) && st.dbuf == {$past(WDATA), $past(st.tmp)})
    else $error("buffered write reached the compare value");

  a_dbuf_copy: assert property (
    hit && st.dbf |=> st.act == $past(st.dbuf) && TIMER_INTERRUPT_REQUEST)
    else $error("match did not move the buffer into compare");

  a_match_clear: assert property (
    hit && !(WR && ADDR == `TCA_CTL)
    |=> st.cnt == 16'h0000 && TIMER_INTERRUPT_REQUEST ##1 !TIMER_INTERRUPT_REQUEST)
    else $error("match did not clear the counter with one interrupt");

  a_read_dbuf: assert property (
    RD && ADDR == `TCA_CMP_LO && st.dbf |=> RDATA == $past(st.dbuf[7:0]))
    else $error("compare read did not return the buffer");

  a_stop_clear: assert property (
    st.run && WR && ADDR == `TCA_CTL && !WDATA[`TCA_CTL_RUN]
    |=> st.cnt == 16'h0000 && !st.run && !st.going)
    else $error("stop did not clear the counter");

  a_mode_lock: assert property (
    st.run && WR && ADDR == `TCA_MODE |=> $stable(st.mode) && $stable(st.ted))
    else $error("mode changed while running");

  a_retrig_stop: assert property (
    s_trig_going ##0 opp_edge && !(WR && ADDR == `TCA_CTL)
    |=> !st.going && st.cnt == 16'h0000)
    else $error("opposite edge did not stop the trigger count");

  a_event_step: assert property (
    st.run && st.mode == `TCA_M_EVENT && sel_edge && !hit && !WR
    |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("event edge did not advance the counter");

  a_no_irq_idle: assert property (
    !st.run ##1 !st.run |-> !TIMER_INTERRUPT_REQUEST)
    else $error("interrupt while stopped");

  // Interrupt is a single pulse and only follows a match
  a_irq_pulse: assert property (
    TIMER_INTERRUPT_REQUEST |=> !TIMER_INTERRUPT_REQUEST)
    else $error("interrupt longer than one cycle");

  a_irq_cause: assert property (
    TIMER_INTERRUPT_REQUEST |-> $past(hit))
    else $error("interrupt without a match");

  a_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside the read answer cycle");

  a_stopped_zero: assert property (
    !st.run |-> st.cnt == 16'h0000)
    else $error("stopped counter not at zero");

  a_run_bit: assert property (
    WR && ADDR == `TCA_CTL |=> st.run == $past(WDATA[`TCA_CTL_RUN]))
    else $error("run bit did not follow the write");

  a_dbf_bit: assert property (
    WR && ADDR == `TCA_CTL |=> st.dbf == $past(WDATA[`TCA_CTL_DBF]))
    else $error("double buffer bit did not follow the write");

  a_ove_lock: assert property (
    st.run && WR && ADDR == `TCA_CTL |=> $stable(st.ove))
    else $error("overflow enable changed while running");

  a_unbuf_load: assert property (
    s_hi_write ##0 !st.dbf
    |=> st.act == {$past(WDATA), $past(st.tmp)})
    else $error("unbuffered write did not reach the compare value");

  a_stop_load: assert property (
    s_hi_write ##0 (st.dbf && !st.run) |=> st.act == st.dbuf)
    else $error("stopped buffered write did not load both");

  a_read_hi_buf: assert property (
    RD && ADDR == `TCA_CMP_HI && st.dbf |=> RDATA == $past(st.dbuf[15:8]))
    else $error("compare high read did not return the buffer");

  // Trigger mode waits idle at zero until the start edge
  a_trig_wait: assert property (
    st.run && st.mode == `TCA_M_TRIG && !st.going |-> st.cnt == 16'h0000)
    else $error("trigger count moved before the start edge");

  a_trig_start: assert property (
    st.run && st.mode == `TCA_M_TRIG && !st.going && sel_edge
    && !(WR && ADDR == `TCA_CTL) |=> st.going)
    else $error("trigger edge did not start counting");

  a_retrig_hold: assert property (
    st.run && st.mode == `TCA_M_TRIG && st.going && !st.mett
    && !(WR && ADDR == `TCA_CTL) |=> st.going)
    else $error("edge stopped a trigger count without retrigger");

  a_event_hold: assert property (
    st.run && st.mode == `TCA_M_EVENT && !sel_edge
    && !(WR && ADDR == `TCA_CTL) |=> $stable(st.cnt))
    else $error("event counter moved without an edge");

  // Window counts only at the chosen level
  a_win_hold: assert property (
    st.run && st.mode == `TCA_M_WINDOW && st.sync2 == st.ted
    && !(WR && ADDR == `TCA_CTL) |=> $stable(st.cnt))
    else $error("window counted outside the window");

  a_win_step: assert property (
    st.run && st.mode == `TCA_M_WINDOW && tick && st.sync2 != st.ted
    && !hit && !(WR && ADDR == `TCA_CTL)
    |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("window tick did not advance the counter");

  a_edge_sync: assert property (
    rise |-> $past(st.sync1) && !$past(st.sync2))
    else $error("edge seen without two sampled levels");

  // Capture of the live count on the low byte read
  a_cap_latch: assert property (
    RD && ADDR == `TCA_CAP_LO && st.acap && st.run
    |=> st.cap == $past(st.cnt) && RDATA == $past(st.cnt[7:0]))
    else $error("capture read did not latch the count");

  a_cap_stopped: assert property (
    RD && ADDR == `TCA_CAP_LO && st.acap && !st.run
    |=> RDATA == 8'h00 && st.cap == 16'h0000)
    else $error("stopped capture read not zero");

  a_acap_keep: assert property (
    st.run && WR && ADDR == `TCA_CTL && !WDATA[`TCA_CTL_RUN]
    |=> $stable(st.acap))
    else $error("auto capture changed by the stopping write");

endmodule

`default_nettype wire

// >>> verif/tca_pulse_src.sv
// Purpose: Pulse source standing on the timer input pin
// Assumes: Bench sets the idle level before the event and compare buffering tests
// Notes:   Every level is held two clocks or more
`timescale 1ns/1ps
`default_nettype none

module tca_pulse_src (
  input  wire logic CLK,
  output logic      PIN
);
  // Always driven: the pin is an input of the timer
  initial PIN = 1'b0;

  task automatic lvl(input logic v);
    @(posedge CLK);
    PIN <= v;
  endtask

  // One full pulse away from the idle level and back
  task automatic pulse(input int hi, input int lo);
    @(posedge CLK);
    PIN <= ~PIN;
    repeat (hi) @(posedge CLK);
    PIN <= ~PIN;
    repeat (lo) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// >>> verif/tca_timer_tb.sv
// Purpose: Self-checking bench of the timer
// Assumes: Read data stand in the cycle after the read strobe
// Notes:   Interrupt pulses are counted by the watcher
`timescale 1ns/1ps
`default_nettype none

module tca_timer_tb;
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        rd_d  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        pin;
  logic        irq;
  logic [7:0]  expq[$];
  logic [31:0] seed  = 32'h48;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          n_irq      = 0;
  int          i0;

  tca_timer u_tca_timer (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TIMER_INPUT_PIN(pin),
    .TIMER_INTERRUPT_REQUEST(irq));
  tca_pulse_src u_tca_pulse_src (.CLK(clk), .PIN(pin));

  initial forever #20 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    expq.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Low byte strictly before high byte
  task automatic cmp(input logic [15:0] v);
    reg_wr(8'h2d, v[7:0]);
    reg_wr(8'h2e, v[15:8]);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      seed = xs(seed);
      u_tca_pulse_src.pulse(2 + seed[1:0], 2 + seed[3:2]);
    end
    repeat (4) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (irq === 1'b1)
      n_irq++;
    if (rd_d)
      chk(rdata, expq.pop_front());
    rd_d <= rd;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(8'h2d, 8'hff);
    reg_rd(8'h31, 8'h00);
    reg_rd(8'h40, 8'h00);
    reg_wr(8'h2d, 8'h34);
    reg_rd(8'h2d, 8'hff);
    reg_wr(8'h2e, 8'h12);
    reg_rd(8'h2d, 8'h34);
    reg_rd(8'h2e, 8'h12);
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      u_tca_pulse_src.lvl(t[0]);
      cmp(16'h0003);
      reg_wr(8'h32, {2'b00, t[0], 5'h02});
      reg_wr(8'h31, 8'h09);
      reg_wr(8'h32, 8'h05);
      reg_rd(8'h32, {2'b00, t[0], 5'h02});
      reg_wr(8'h31, 8'h0d);
      reg_rd(8'h31, 8'h09);
      i0 = n_irq;
      pulses(4);
      chk(16'(n_irq - i0), 16'h0001);
      pulses(3);
      reg_rd(8'h2f, 8'h03);
      reg_rd(8'h30, 8'h00);
      reg_wr(8'h31, 8'h08);
      reg_rd(8'h2f, 8'h00);
      reg_rd(8'h30, 8'h00);
      $display("test event edge %0d done", t);
    end
    u_tca_pulse_src.lvl(1'b0);
    reg_wr(8'h32, 8'h02);
    cmp(16'h0005);
    reg_wr(8'h31, 8'h01);
    pulses(3);
    cmp(16'h0001);
    i0 = n_irq;
    pulses(2);
    chk(16'(n_irq - i0), 16'h0000);
    cmp(16'h0006);
    pulses(2);
    chk(16'(n_irq - i0), 16'h0001);
    reg_wr(8'h31, 8'h00);
    reg_wr(8'h31, 8'h02);
    cmp(16'h0001);
    reg_wr(8'h31, 8'h03);
    cmp(16'h0004);
    reg_rd(8'h2d, 8'h04);
    i0 = n_irq;
    pulses(2);
    chk(16'(n_irq - i0), 16'h0001);
    pulses(4);
    chk(16'(n_irq - i0), 16'h0001);
    pulses(1);
    chk(16'(n_irq - i0), 16'h0002);
    reg_wr(8'h31, 8'h00);
    $display("test compare buffering done");
    for (int m = 0; m < 2; m++) begin
      cmp(16'h0009);
      reg_wr(8'h32, {1'b0, m[0], 6'h1c});
      reg_wr(8'h31, 8'h01);
      i0 = n_irq;
      repeat (40) @(posedge clk);
      chk(16'(n_irq - i0), 16'h0000);
      u_tca_pulse_src.lvl(1'b1);
      repeat (10) @(posedge clk);
      u_tca_pulse_src.lvl(1'b0);
      repeat (20) @(posedge clk);
      chk(16'(n_irq - i0), 16'(1 - m));
      if (m == 1) begin
        u_tca_pulse_src.lvl(1'b1);
        repeat (30) @(posedge clk);
        chk(16'(n_irq - i0), 16'h0001);
      end
      reg_wr(8'h31, 8'h00);
      $display("test trigger retrigger %0d done", m);
    end
    // Window held far longer than the source tick
    cmp(16'h0003);
    reg_wr(8'h32, 8'h3d);
    reg_wr(8'h31, 8'h01);
    i0 = n_irq;
    repeat (40) @(posedge clk);
    chk(16'(n_irq - i0), 16'h0000);
    u_tca_pulse_src.lvl(1'b0);
    repeat (14) @(posedge clk);
    chk(16'(n_irq - i0), 16'h0001);
    $display("test window done");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
